// ### design/code_lock_crc_pkg.sv
// package: register map, field layout and constants of the code lock and checksum block
`default_nettype none
package code_lock_crc_pkg;
   // ----------------------------------------------------------------
   // register byte addresses (aligned words on the register bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CODE_ADDRESS      = 8'h00;
   localparam logic [7:0] ADDR_CODE_DATA         = 8'h04;
   localparam logic [7:0] ADDR_PROGRAM_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_INTERFACE_STATUS  = 8'h0c;
   localparam logic [7:0] ADDR_CHECKSUM_BYTE0    = 8'h10;
   localparam logic [7:0] ADDR_CHECKSUM_BYTE1    = 8'h14;
   localparam logic [7:0] ADDR_CHECKSUM_BYTE2    = 8'h18;
   localparam logic [7:0] ADDR_CHECKSUM_BYTE3    = 8'h1c;
   localparam logic [7:0] ADDR_SECURITY_ADDRESS  = 8'h20;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int STAT_ERROR_BIT      = 0;
   localparam int STAT_WRITE_PROT_BIT = 6;
   localparam int STAT_READ_PROT_BIT  = 7;
   localparam int BUSY_FLAG_BIT       = 1;
   // security byte: low nibble write-protect bits, high nibble read-protect bits
   localparam int SEC_WRITE_LSB       = 0;
   localparam int SEC_READ_LSB        = 4;
   // ----------------------------------------------------------------
   // reset values and polynomials
   // ----------------------------------------------------------------
   localparam logic [15:0] CODE_ADDRESS_RESET = 16'h0000;
   localparam logic [31:0] CRC32_POLY        = 32'h04c11db7;
   localparam logic [15:0] CRC16_POLY        = 16'h1021;
   localparam logic [31:0] CRC32_SEED        = 32'hffffffff;
   localparam logic [15:0] CRC16_SEED        = 16'h0000;
   localparam logic [15:0] FULL_SPAN_START   = 16'h0000;
   localparam logic [7:0]  BLOCK_LOW_BYTE    = 8'h00;
   localparam logic [8:0]  BLOCK_BYTES       = 9'h100;
   localparam logic [31:0] PSLVERR_NONE      = 32'h00000000;

   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef enum logic [1:0] {
      CRC_IDLE,
      CRC_FETCH,
      CRC_SHIFT
   } crc_state_t;
endpackage
`default_nettype wire

// ### design/code_lock_crc.sv
// code memory lock decoding and checksum engine with an apb register slave
//
// Contract
// RQ1 - lock settings come from a security byte
// RQ2 - any write-protect zero bit refuses writes
// RQ3 - any read-protect zero bit refuses reads
// RQ4 - status shows locks for addressed location
// RQ5 - no mechanism ever removes the lock
// RQ6 - programmer sets write lock only last
// RQ7 - checksum runs even when fully locked
// RQ8 - block checksums only aligned 256 bytes
// RQ9 - checksum byte one write starts crc32
// RQ10 - busy flag high while checksum runs
// RQ11 - crc32 result byte three most significant
// RQ12 - crc32 polynomial is 04c11db7
// RQ13 - checksum byte zero write starts block crc16
// RQ14 - crc16 result byte one most significant
// RQ15 - crc16 polynomial is 1021
// RQ16 - programmer resets before crc32 after crc16
// RQ17 - data access advances code address by one
// RQ18 - status offers an error bit
// RQ19 - engine reads ascending, bypasses locks, hides bytes
// RQ20 - start writes ignored while busy
`timescale 1ns/10ps
`default_nettype none
module code_lock_crc
   import code_lock_crc_pkg::*;
#(
   parameter int CODE_AW = 14
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [7:0]        i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   output logic      [CODE_AW-1:0] o_mem_addr,
   output logic                   o_mem_wr,
   output logic      [7:0]        o_mem_wdata,
   input  wire logic [7:0]        i_mem_rdata
);
   localparam int CODE_BYTES = 1 << CODE_AW;
   localparam logic [CODE_AW-1:0] LAST_ADDR = CODE_AW'(CODE_BYTES - 1);
   localparam logic [CODE_AW-1:0] SEC_ADDR  = LAST_ADDR;

   // ----------------------------------------------------------------
   // code memory and security byte
   // ----------------------------------------------------------------
   // one-time programmable array: a bit once cleared never returns to one
   // blank cells read as all ones, so an unwritten security byte leaves the part open
   logic [7:0] mem_r [CODE_BYTES] = '{default: 8'hff};

   logic [7:0]         sec_byte;
   logic               read_protect_flag;
   logic               write_protect_flag;
   assign sec_byte           = mem_r[SEC_ADDR];                               // [RQ1]
   assign write_protect_flag = ~&sec_byte[SEC_WRITE_LSB +: 4];                // [RQ2]
   assign read_protect_flag  = ~&sec_byte[SEC_READ_LSB +: 4];                 // [RQ3]

   // ----------------------------------------------------------------
   // bus and programming registers
   // ----------------------------------------------------------------
   bus_req_t           req;
   logic               access;
   assign req    = '{wr: i_pwrite, addr: i_paddr, wdata: i_pwdata};
   assign access = i_psel & i_penable & ~o_pready;

   logic [15:0]        code_address_reg_r, code_address_reg_nxt;
   logic               err_r, err_nxt;
   logic [31:0]        prdata_nxt;
   logic               pready_nxt, pslverr_nxt;
   logic               mem_wr_nxt;
   logic [7:0]         mem_wdata_nxt;
   logic [CODE_AW-1:0] mem_addr_nxt;
   logic               start32, start16;
   logic [7:0]         block_hi;
   logic               busy_r;
   logic [31:0]        crc_r;
   logic [CODE_AW-1:0] cur_addr;
   logic [7:0]         program_status_reg;

   assign cur_addr = code_address_reg_r[CODE_AW-1:0];
   // lock state applies to whichever location the address register points at
   assign program_status_reg = {read_protect_flag, write_protect_flag, 5'h00, err_r}; // [RQ4] [RQ18]

   always_comb begin
      code_address_reg_nxt = code_address_reg_r;
      err_nxt              = err_r;
      prdata_nxt           = 32'h00000000;
      pready_nxt           = 1'b0;
      pslverr_nxt          = 1'b0;
      mem_wr_nxt           = 1'b0;
      mem_wdata_nxt        = 8'h00;
      mem_addr_nxt         = cur_addr;
      start32              = 1'b0;
      start16              = 1'b0;
      block_hi             = 8'h00;
      if (access) begin
         pready_nxt = 1'b1;
         case (req.addr)
            ADDR_CODE_ADDRESS: begin
               if (req.wr) begin
                  code_address_reg_nxt = req.wdata[15:0];
               end else begin
                  prdata_nxt = {16'h0000, code_address_reg_r};
               end
            end
            ADDR_CODE_DATA: begin
               code_address_reg_nxt = code_address_reg_r + 16'h0001;            // [RQ17]
               if (req.wr) begin
                  if (write_protect_flag) begin
                     err_nxt = 1'b1;                                          // [RQ2]
                  end else begin
                     // programming can only clear bits, so the lock never lifts
                     mem_wr_nxt    = 1'b1;                                    // [RQ5]
                     mem_wdata_nxt = req.wdata[7:0];
                     err_nxt       = 1'b0;
                  end
               end else if (read_protect_flag) begin
                  err_nxt = 1'b1;                                             // [RQ3]
               end else begin
                  prdata_nxt = {24'h000000, mem_r[cur_addr]};
                  err_nxt    = 1'b0;
               end
            end
            ADDR_PROGRAM_STATUS: begin
               if (!req.wr) begin
                  prdata_nxt = {24'h000000, program_status_reg};              // [RQ4]
               end
            end
            ADDR_INTERFACE_STATUS: begin
               if (!req.wr) begin
                  prdata_nxt = 32'(busy_r) << BUSY_FLAG_BIT;                  // [RQ10]
               end
            end
            ADDR_CHECKSUM_BYTE0: begin
               if (req.wr) begin
                  start16  = ~busy_r;                                         // [RQ13] [RQ20]
                  block_hi = req.wdata[7:0];
               end else begin
                  prdata_nxt = {24'h000000, crc_r[7:0]};
               end
            end
            ADDR_CHECKSUM_BYTE1: begin
               if (req.wr) begin
                  start32 = ~busy_r;                                          // [RQ9] [RQ20]
               end else begin
                  prdata_nxt = {24'h000000, crc_r[15:8]};
               end
            end
            ADDR_CHECKSUM_BYTE2: prdata_nxt = req.wr ? 32'h00000000 : {24'h000000, crc_r[23:16]};
            ADDR_CHECKSUM_BYTE3: prdata_nxt = req.wr ? 32'h00000000 : {24'h000000, crc_r[31:24]};
            ADDR_SECURITY_ADDRESS: prdata_nxt = req.wr ? 32'h00000000 : 32'(SEC_ADDR);
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         code_address_reg_r <= CODE_ADDRESS_RESET;
         err_r              <= 1'b0;
         o_prdata           <= 32'h00000000;
         o_pready           <= 1'b0;
         o_pslverr          <= 1'b0;
         o_mem_wr           <= 1'b0;
         o_mem_wdata        <= 8'h00;
         o_mem_addr         <= '0;
      end else begin
         code_address_reg_r <= code_address_reg_nxt;
         err_r              <= err_nxt;
         o_prdata           <= prdata_nxt;
         o_pready           <= pready_nxt;
         o_pslverr          <= pslverr_nxt;
         o_mem_wr           <= mem_wr_nxt;
         o_mem_wdata        <= mem_wdata_nxt;
         o_mem_addr         <= mem_addr_nxt;
      end
   end

   // array is not reset: programmed content survives a device reset
   always_ff @(posedge i_core_clk) begin
      if (!i_reset && mem_wr_nxt) begin
         mem_r[cur_addr] <= mem_r[cur_addr] & mem_wdata_nxt;                 // [RQ5]
      end
   end

   // ----------------------------------------------------------------
   // checksum engine
   // ----------------------------------------------------------------
   crc_state_t         state_r, state_nxt;
   logic               busy_nxt;
   logic               mode32_r, mode32_nxt;
   logic [CODE_AW-1:0] scan_r, scan_nxt;
   logic [CODE_AW-1:0] scan_end_r, scan_end_nxt;
   logic [7:0]         byte_r, byte_nxt;
   logic [3:0]         bit_r, bit_nxt;
   logic [31:0]        crc_nxt;
   logic               fb32, fb16;

   assign fb32 = crc_r[31] ^ byte_r[7];
   assign fb16 = crc_r[15] ^ byte_r[7];

   always_comb begin
      state_nxt    = state_r;
      busy_nxt     = busy_r;
      mode32_nxt   = mode32_r;
      scan_nxt     = scan_r;
      scan_end_nxt = scan_end_r;
      byte_nxt     = byte_r;
      bit_nxt      = bit_r;
      crc_nxt      = crc_r;
      case (state_r)
         CRC_IDLE: begin
            if (start32) begin
               state_nxt    = CRC_FETCH;
               busy_nxt     = 1'b1;                                           // [RQ10]
               mode32_nxt   = 1'b1;
               scan_nxt     = FULL_SPAN_START[CODE_AW-1:0];                   // [RQ9]
               scan_end_nxt = LAST_ADDR;
               crc_nxt      = CRC32_SEED;
            end else if (start16) begin
               state_nxt    = CRC_FETCH;
               busy_nxt     = 1'b1;                                           // [RQ10]
               mode32_nxt   = 1'b0;
               // start forced to a 256 byte boundary, span fixed at 256
               scan_nxt     = CODE_AW'({block_hi, BLOCK_LOW_BYTE});           // [RQ8]
               scan_end_nxt = CODE_AW'({block_hi, BLOCK_LOW_BYTE} + 16'(BLOCK_BYTES - 9'h001)); // [RQ8]
               crc_nxt      = {16'h0000, CRC16_SEED};
            end
         end
         CRC_FETCH: begin
            // direct array read, no lock check, byte never leaves the engine
            byte_nxt  = mem_r[scan_r];                                        // [RQ7] [RQ19]
            bit_nxt   = 4'h0;
            state_nxt = CRC_SHIFT;
         end
         CRC_SHIFT: begin
            byte_nxt = {byte_r[6:0], 1'b0};
            bit_nxt  = bit_r + 4'h1;
            if (mode32_r) begin
               crc_nxt = {crc_r[30:0], 1'b0} ^ (fb32 ? CRC32_POLY : 32'h00000000); // [RQ12]
            end else begin
               crc_nxt = {16'h0000, {crc_r[14:0], 1'b0} ^ (fb16 ? CRC16_POLY : 16'h0000)}; // [RQ15]
            end
            if (bit_r == 4'h7) begin
               if (scan_r == scan_end_r) begin
                  state_nxt = CRC_IDLE;
                  busy_nxt  = 1'b0;                                           // [RQ10]
               end else begin
                  scan_nxt  = scan_r + CODE_AW'(1);                           // [RQ19]
                  state_nxt = CRC_FETCH;
               end
            end
         end
         default: begin
            state_nxt = CRC_IDLE;
            busy_nxt  = 1'b0;
         end
      endcase
   end

   // result bytes: byte3..byte0 for crc32, byte1..byte0 for crc16
   always_ff @(posedge i_core_clk) begin                                      // [RQ11] [RQ14]
      if (i_reset) begin
         state_r    <= CRC_IDLE;
         busy_r     <= 1'b0;
         mode32_r   <= 1'b0;
         scan_r     <= '0;
         scan_end_r <= '0;
         byte_r     <= 8'h00;
         bit_r      <= 4'h0;
         crc_r      <= 32'h00000000;
      end else begin
         state_r    <= state_nxt;
         busy_r     <= busy_nxt;
         mode32_r   <= mode32_nxt;
         scan_r     <= scan_nxt;
         scan_end_r <= scan_end_nxt;
         byte_r     <= byte_nxt;
         bit_r      <= bit_nxt;
         crc_r      <= crc_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   a_write_lock_blocks: assert property (mem_wr_nxt |-> !write_protect_flag)            // [RQ2]
      else $error("write reached code memory while write protected");
   a_read_lock_err: assert property (access && req.addr == ADDR_CODE_DATA && !req.wr && read_protect_flag // [RQ3]
      |=> err_r && o_prdata == 32'h00000000)
      else $error("protected read not refused");
   a_addr_advance: assert property (access && req.addr == ADDR_CODE_DATA                // [RQ17]
      |=> code_address_reg_r == $past(code_address_reg_r) + 16'h0001)
      else $error("code address did not advance");
   a_busy_on_start: assert property (state_r == CRC_IDLE && (start16 || start32) |=> busy_r) // [RQ10]
      else $error("busy not raised on checksum start");
   a_busy_follows_fsm: assert property (busy_r == (state_r != CRC_IDLE))               // [RQ10]
      else $error("busy flag disagrees with engine");
   a_block_aligned: assert property (state_r == CRC_IDLE && start16 && !start32         // [RQ8]
      |=> scan_r[7:0] == 8'h00 && scan_end_r == scan_r + CODE_AW'(255))
      else $error("block span not aligned 256 bytes");
   // a start write that lands while busy must leave the running span and mode alone
   a_start_ignored: assert property (busy_r && access && req.wr                          // [RQ20]
      && (req.addr == ADDR_CHECKSUM_BYTE0 || req.addr == ADDR_CHECKSUM_BYTE1)
      |=> $stable(mode32_r) && $stable(scan_end_r) && busy_r == (state_r != CRC_IDLE))
      else $error("running checksum disturbed");
   a_crc16_upper_zero: assert property (!mode32_r && state_r != CRC_IDLE |=> crc_r[31:16] == 16'h0000) // [RQ14]
      else $error("crc16 upper bytes not zero");
   a_status_locks: assert property (access && req.addr == ADDR_PROGRAM_STATUS && !req.wr // [RQ4]
      |=> o_prdata[STAT_READ_PROT_BIT] == $past(read_protect_flag))
      else $error("status lock bit wrong");
   a_shift_eight: assert property (state_r == CRC_FETCH |=> state_r == CRC_SHIFT [*8] ##1 state_r != CRC_SHIFT) // [RQ12]
      else $error("byte not shifted in eight steps");

   c_crc32_run:  cover property (state_r == CRC_IDLE && start32);
   c_crc16_run:  cover property (state_r == CRC_IDLE && start16);
   c_lock_error: cover property (access && req.addr == ADDR_CODE_DATA && write_protect_flag && req.wr);
   c_done:       cover property (busy_r ##1 !busy_r);
endmodule
`default_nettype wire

// ### testbench/apb_programmer.sv
// programmer model: drives register transfers into the block over apb
`timescale 1ns/10ps
`default_nettype none
module apb_programmer (
   input  wire logic        i_core_clk,
   input  wire logic        i_pready,
   input  wire logic [31:0] i_prdata,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [7:0]       o_paddr,
   output logic [31:0]      o_pwdata
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h00000000;
   end

   // one transfer: setup, access held until ready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge i_core_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_core_clk);
      o_penable <= 1'b1;
      // no wait limit here: only the bench timeout ends a hung transfer
      do begin
         @(posedge i_core_clk);
      end while (i_pready !== 1'b1);
      r = i_prdata;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released lines must not keep looking valid
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_code_lock_crc.sv
// self-checking bench for the code lock and checksum block
`timescale 1ns/10ps
`default_nettype none
module tb_code_lock_crc;
   import code_lock_crc_pkg::*;
   localparam int AW = 9;
   localparam int LAST = (1 << AW) - 1;
   typedef struct packed {logic chk; logic err; logic [31:0] d;} note_t;
   logic core_clk, reset, psel, penable, pwrite, pready, pslverr, mem_wr;
   logic [7:0] paddr, mem_wdata;
   logic [31:0] pwdata, prdata;
   logic [AW-1:0] mem_addr;
   logic [7:0] mem [0:LAST];
   note_t notes[$];
   logic [31:0] echoes[$];
   int bad_count, cmp_count, cur, cyc;

   code_lock_crc #(.CODE_AW(AW)) code_lock_crc_inst (.i_core_clk(core_clk), .i_reset(reset), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_mem_addr(mem_addr), .o_mem_wr(mem_wr),
      .o_mem_wdata(mem_wdata), .i_mem_rdata(8'h00));
   apb_programmer apb_programmer_inst (.i_core_clk(core_clk), .i_pready(pready), .i_prdata(prdata),
      .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_echo(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge core_clk) begin
      note_t n;
      cyc++;
      if (pready === 1'b1) begin
         n = notes.size() ? notes.pop_front() : note_t'{1'b1, 1'b1, 32'hxxxxxxxx};
         check({31'h0, pslverr}, {31'h0, n.err});
         if (n.chk) check(prdata, n.d);
      end
      if (mem_wr === 1'b1) check_echo({15'h0, mem_addr, mem_wdata}, echoes.size() ? echoes.pop_front() : 32'hxxxxxxxx);
      if (cyc == 60000) begin
         bad_count++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // stimulus helpers: each transfer leaves its expected answer first
   // ----------------------------------------------------------------
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic chk,
                      input logic [31:0] e, input logic er, output logic [31:0] r);
      notes.push_back('{chk, er, e});
      apb_programmer_inst.xfer(w, a, d, r);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      acc(1'b1, a, d, 1'b0, 32'h0, 1'b0, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      acc(1'b0, a, 32'h0, 1'b1, e, 1'b0, r);
   endtask

   // otp bits only clear, so the model ands each new byte in
   task automatic prog(input logic [7:0] v);
      mem[cur] = mem[cur] & v;
      echoes.push_back(32'(cur) << 8 | 32'(v));
      wr(ADDR_CODE_DATA, {24'h0, v});
      cur++;
   endtask

   task automatic wait_idle;
      logic [31:0] r;
      for (int n = 0; n < 2000; n++) begin
         acc(1'b0, ADDR_INTERFACE_STATUS, 32'h0, 1'b0, 32'h0, 1'b0, r);
         if (r[BUSY_FLAG_BIT] === 1'b0) break;
      end
      rd(ADDR_INTERFACE_STATUS, 32'h0);
   endtask

   function automatic logic [31:0] crc(input int lo, input int n, input bit big);
      logic [31:0] c;
      logic fb;
      c = big ? CRC32_SEED : {16'h0, CRC16_SEED};
      for (int i = lo; i < lo + n; i++)
         for (int b = 7; b >= 0; b--) begin
            fb = c[big ? 31 : 15] ^ mem[i][b];
            c = c << 1;
            if (fb) c ^= big ? CRC32_POLY : {16'h0, CRC16_POLY};
         end
      return big ? c : {16'h0, c[15:0]};
   endfunction

   task automatic rd_crc(input logic [31:0] c, input int nb);
      for (int k = 0; k < nb; k++) rd(ADDR_CHECKSUM_BYTE0 + 8'(4 * k), {24'h0, c[8*k +: 8]});
   endtask

   task automatic block_crc(input int blk);
      wr(ADDR_CHECKSUM_BYTE0, 32'(blk));
      rd(ADDR_INTERFACE_STATUS, 32'h2);
      wr(ADDR_CHECKSUM_BYTE1, 32'h0);
      wait_idle();
      rd_crc(crc(blk * 256, 256, 1'b0), 2);
   endtask

   task automatic pulse_reset(input int n);
      reset <= 1'b1;
      repeat (n) @(posedge core_clk);
      reset <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] r;
      reset = 1'b1;
      foreach (mem[i]) mem[i] = 8'hff;
      r = $urandom(77134);
      pulse_reset(12);
      rd(ADDR_PROGRAM_STATUS, 32'h0);
      for (int k = 0; k < 4; k++) rd(ADDR_CHECKSUM_BYTE0 + 8'(4 * k), 32'h0);
      rd(ADDR_SECURITY_ADDRESS, 32'(LAST));
      acc(1'b0, 8'h24, 32'h0, 1'b1, 32'h0, 1'b1, r);
      $display("test reset values done");
      wr(ADDR_CODE_ADDRESS, 32'h0);
      cur = 0;
      for (int i = 0; i < LAST; i++) prog(8'($urandom));
      prog(8'hff);
      wr(ADDR_CODE_ADDRESS, 32'h5);
      cur = 5;
      prog(8'h3c);
      wr(ADDR_CODE_ADDRESS, 32'h0);
      for (int i = 0; i < 8; i++) rd(ADDR_CODE_DATA, {24'h0, mem[i]});
      rd(ADDR_CODE_ADDRESS, 32'h8);
      rd(ADDR_PROGRAM_STATUS, 32'h0);
      $display("test programming done");
      block_crc(0);
      block_crc(1);
      $display("test block checksum done");
      pulse_reset(2);
      wr(ADDR_CHECKSUM_BYTE1, 32'h0);
      wait_idle();
      rd_crc(crc(0, LAST + 1, 1'b1), 4);
      $display("test full checksum done");
      wr(ADDR_CODE_ADDRESS, 32'(LAST));
      cur = LAST;
      prog(8'h7e);
      for (int a = 0; a < 512; a += 256) begin
         wr(ADDR_CODE_ADDRESS, 32'(a));
         rd(ADDR_PROGRAM_STATUS, 32'hc0);
      end
      wr(ADDR_CODE_ADDRESS, 32'h0);
      rd(ADDR_CODE_DATA, 32'h0);
      rd(ADDR_PROGRAM_STATUS, 32'hc1);
      wr(ADDR_CODE_ADDRESS, 32'h2);
      wr(ADDR_CODE_DATA, 32'h0);
      rd(ADDR_PROGRAM_STATUS, 32'hc1);
      pulse_reset(2);
      rd(ADDR_PROGRAM_STATUS, 32'hc0);
      block_crc(0);
      $display("test lock done");
      repeat (4) @(posedge core_clk);
      check(32'(notes.size() + echoes.size()), 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
